// [rtl/actb_pkg.sv]
// shared constants and types for the control-byte decoder and track/hold sequencer
package actb_pkg;
   localparam int CTRL_BITS = 8;
   localparam int START_POS = 7;
   localparam int SEL_HI = 6;
   localparam int SEL_LO = 4;
   localparam int POL_POS = 3;
   localparam int CFG_POS = 2;
   localparam int MODE_HI = 1;
   localparam int MODE_LO = 0;
   localparam int RESULT_BITS = 10;
   localparam logic [3:0] TRACK_AT = 4'h5;
   localparam logic [3:0] HOLD_AT = 4'h8;
   localparam logic [3:0] CNT_RESET = 4'h0;
   // internal conversion clock: cycles per bit decision
   localparam int INT_BIT_NS = 700;
   localparam int CLK_NS = 100;
   localparam logic [3:0] INT_BIT_CYC = 4'((INT_BIT_NS + CLK_NS - 1) / CLK_NS);
   // least acquisition time the host must leave, in ns
   localparam int ACQ_MIN_NS = 1500;
   localparam int ACQ_MIN_CYC = (ACQ_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0] SEL_A = 3'h1;
   localparam logic [2:0] SEL_B = 3'h5;
   localparam logic [2:0] SEL_C = 3'h2;
   localparam logic [2:0] SEL_D = 3'h6;
   localparam logic [1:0] MODE_FULL_PD = 2'h0;
   localparam logic [1:0] MODE_FAST_PD = 2'h1;
   localparam logic [1:0] MODE_INT_CLK = 2'h2;
   localparam logic [1:0] MODE_EXT_CLK = 2'h3;

   typedef struct packed {
      logic [2:0] chan_select;
      logic polarity_select;
      logic input_config_select;
      logic [1:0] op_mode;
   } actb_ctrl_s;

   // analog switch controls: one-hot channel to positive node, negative node source
   typedef struct packed {
      logic track;
      logic [3:0] pos_chan;
      logic [3:0] neg_chan;
      logic neg_to_common;
      logic hold_capacitor_to_pos;
   } actb_switch_s;
endpackage : actb_pkg

// [rtl/actb_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module actb_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= INIT;
         q <= INIT;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : actb_sync
`default_nettype wire

// [rtl/actb_core.sv]
// control-byte decoder, track/hold sequencer and result shifter
// What this block does
// R01 - track on falling edge after bit five
// R02 - hold on falling edge after bit eight
// R03 - single-ended: negative node to common return
// R04 - differential: negative node to paired minus channel; code routes it to common from the bit-five track edge to hold
// R05 - after conversion reconnect hold capacitor positive
// R06 - eight bits msb first, first one starts
// R07 - bits six to four select channels
// R08 - bit three chooses unipolar or bipolar
// R09 - host leaves acquisition at least 1.5us
// R10 - bit two single-ended or differential, code table
// R11 - leading zeros before start are ignored
// R12 - conversion starts when hold is entered
// R13 - straight binary or two's complement, msb first
// R14 - bits one, zero pick operating mode
`timescale 1ns/1ns
`default_nettype none
module actb_core (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic [9:0] sar_code,
   output logic dout,
   output logic dout_oe,
   output var actb_pkg::actb_ctrl_s ctrl,
   output var actb_pkg::actb_switch_s sw,
   output logic converting,
   output logic conv_done,
   output logic [9:0] result,
   output logic powered_down
);
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_SHIFT = 5'h02,
      ST_CONV = 5'h04,
      ST_OUT = 5'h08,
      ST_DONE = 5'h10
   } actb_state_e;

   logic [2:0] pins;
   logic cs_n_s, sclk_s, din_s, sclk_d;
   logic rise, fall;
   actb_state_e state;
   logic [3:0] bit_cnt;
   logic [6:0] shreg;
   logic pend_track, pend_hold;
   logic [3:0] conv_cnt;
   logic [3:0] tick;
   logic [9:0] out_sh;
   logic [3:0] out_cnt;
   logic [9:0] coded_now;

   actb_sync #(.W(3), .INIT(3'h4)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({cs_n, sclk, din}),
      .q(pins)
   );
   assign cs_n_s = pins[2];
   assign sclk_s = pins[1];
   assign din_s = pins[0];

   always_ff @(posedge clk) begin
      if (rst) sclk_d <= 1'b0;
      else sclk_d <= sclk_s;
   end
   assign rise = sclk_s & ~sclk_d & ~cs_n_s;
   assign fall = ~sclk_s & sclk_d;

   // decode of channel code into switch positions
   function automatic actb_pkg::actb_switch_s route(input actb_pkg::actb_ctrl_s c, input logic trk);
      actb_pkg::actb_switch_s s;
      s = '0;
      s.track = trk;
      s.hold_capacitor_to_pos = trk;
      s.neg_to_common = c.input_config_select; // R03
      case (c.chan_select) // R07 R10
         actb_pkg::SEL_A: begin
            s.pos_chan = 4'h1;
            s.neg_chan = c.input_config_select ? 4'h0 : 4'h2; // R04
         end
         actb_pkg::SEL_B: begin
            s.pos_chan = 4'h2;
            s.neg_chan = c.input_config_select ? 4'h0 : 4'h1; // R04
         end
         actb_pkg::SEL_C: begin
            s.pos_chan = 4'h4;
            s.neg_chan = c.input_config_select ? 4'h0 : 4'h8; // R04
         end
         actb_pkg::SEL_D: begin
            s.pos_chan = 4'h8;
            s.neg_chan = c.input_config_select ? 4'h0 : 4'h4; // R04
         end
         default: begin
            s.pos_chan = 4'h0;
            s.neg_chan = 4'h0;
         end
      endcase
      return s;
   endfunction : route

   // byte framing
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ST_IDLE;
         bit_cnt <= actb_pkg::CNT_RESET;
         shreg <= '0;
         ctrl <= '0;
         pend_track <= 1'b0;
         pend_hold <= 1'b0;
      end else begin
         if (fall && pend_track) pend_track <= 1'b0;
         if (fall && pend_hold) pend_hold <= 1'b0;
         case (state)
            ST_IDLE, ST_DONE, ST_OUT: begin
               // a new start bit aborts any result still shifting
               if (rise && din_s) begin // R06 R11
                  state <= ST_SHIFT;
                  bit_cnt <= 4'h1;
                  shreg <= '0;
               end else if (state == ST_OUT && (cs_n_s || out_cnt == 4'h0)) begin
                  // result fully shifted or host released the chip
                  state <= ST_DONE;
               end
            end
            ST_SHIFT: begin
               if (cs_n_s) begin
                  state <= ST_IDLE;
                  bit_cnt <= actb_pkg::CNT_RESET;
               end else if (rise) begin
                  shreg <= {shreg[5:0], din_s}; // R06
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt + 4'h1 == actb_pkg::TRACK_AT) pend_track <= 1'b1;
                  if (bit_cnt + 4'h1 == actb_pkg::HOLD_AT) begin
                     pend_hold <= 1'b1;
                     ctrl <= actb_pkg::actb_ctrl_s'({shreg[5:0], din_s}); // R07 R08 R10 R14
                  end
               end else if (fall && pend_hold) begin
                  state <= ST_CONV; // R12
                  bit_cnt <= actb_pkg::CNT_RESET;
               end
            end
            ST_CONV: begin
               if (conv_cnt == 4'(actb_pkg::RESULT_BITS)) state <= ST_OUT;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // channel bits sit in shreg[3:1] once five bits are in
   function automatic actb_pkg::actb_ctrl_s ctrl_peek(input logic [6:0] r);
      actb_pkg::actb_ctrl_s c;
      c = '0;
      c.chan_select = r[3:1];
      c.input_config_select = 1'b1;
      return c;
   endfunction : ctrl_peek

   // unipolar straight binary; bipolar flips msb of the offset-binary code
   function automatic logic [9:0] code_of(input logic [9:0] raw, input logic uni);
      return uni ? raw : {~raw[9], raw[8:0]};
   endfunction : code_of

   // track/hold switches; host owns acquisition length
   always_ff @(posedge clk) begin
      if (rst) sw <= route('0, 1'b1);
      else if (state == ST_SHIFT && fall && pend_track) sw <= route(ctrl_peek(shreg), 1'b1); // R01
      else if (state == ST_SHIFT && fall && pend_hold) sw <= route(ctrl, 1'b0); // R02
      else if (state == ST_CONV && conv_cnt == 4'(actb_pkg::RESULT_BITS)) sw <= route(ctrl, 1'b1); // R05
   end

   // conversion steps: serial clock in external mode, internal tick otherwise
   always_ff @(posedge clk) begin
      if (rst) begin
         conv_cnt <= '0;
         tick <= '0;
      end else if (state != ST_CONV) begin
         conv_cnt <= '0;
         tick <= '0;
      end else if (ctrl.op_mode == actb_pkg::MODE_EXT_CLK) begin
         if (fall) conv_cnt <= conv_cnt + 4'h1;
      end else if (tick == actb_pkg::INT_BIT_CYC - 4'h1) begin
         tick <= '0;
         conv_cnt <= conv_cnt + 4'h1;
      end else begin
         tick <= tick + 4'h1;
      end
   end

   assign coded_now = code_of(sar_code, ctrl.polarity_select); // R08 R13
   assign converting = (state == ST_CONV);
   assign conv_done = (state == ST_CONV) && (conv_cnt == 4'(actb_pkg::RESULT_BITS));
   assign powered_down = (state == ST_IDLE || state == ST_DONE) &&
                         (ctrl.op_mode == actb_pkg::MODE_FULL_PD || ctrl.op_mode == actb_pkg::MODE_FAST_PD); // R14

   // result coding and shift-out
   always_ff @(posedge clk) begin
      if (rst) begin
         result <= '0;
         out_sh <= '0;
         out_cnt <= '0;
         dout <= 1'b0;
      end else if (conv_done) begin
         result <= coded_now; // R08 R13
         out_sh <= coded_now; // R13
         // external clock mode has already shifted every decision out
         out_cnt <= (ctrl.op_mode == actb_pkg::MODE_EXT_CLK) ? 4'h0 : 4'(actb_pkg::RESULT_BITS);
      end else if (fall && !cs_n_s) begin
         if (state == ST_CONV && ctrl.op_mode == actb_pkg::MODE_EXT_CLK) begin
            // each serial-clock decision appears on its own falling edge
            dout <= coded_now[4'(actb_pkg::RESULT_BITS - 1) - conv_cnt]; // R13
         end else if (state == ST_OUT && out_cnt != 4'h0) begin
            dout <= out_sh[9]; // R13
            out_sh <= {out_sh[8:0], 1'b0};
            out_cnt <= out_cnt - 4'h1;
         end else begin
            dout <= 1'b0;
         end
      end
   end

   assign dout_oe = ~cs_n_s;
endmodule : actb_core
`default_nettype wire

// [testbench/actb_host.sv]
// serial host model: spi mode 0 master driving chip select, clock and data
`timescale 1ns/1ns
`default_nettype none
module actb_host (
   input wire logic clk,
   input wire logic dout,
   output var logic cs_n,
   output var logic sclk,
   output var logic din
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end
   task automatic sel(input logic v);
      cs_n <= v;
      repeat (4) @(posedge clk);
   endtask : sel
   // 800 ns bit period keeps track-to-hold at 2.4 us
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         din <= tx[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         rx[i] = dout;
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
      end
   endtask : xfer
endmodule : actb_host
`default_nettype wire

// [testbench/actb_chk.sv]
// port assertions for the control-byte decoder and track/hold sequencer
`timescale 1ns/1ns
`default_nettype none
module actb_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic [9:0] sar_code,
   input wire actb_pkg::actb_ctrl_s ctrl,
   input wire actb_pkg::actb_switch_s sw,
   input wire logic converting,
   input wire logic conv_done,
   input wire logic [9:0] result,
   input wire logic powered_down
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_TRACK: assert property (!$past(rst) && $changed(sw.pos_chan) && !converting && !$past(converting)
      |-> sw.track && !sclk) else $error("track late");
   AST_HOLD: assert property (!$past(rst) && $fell(sw.track)
      |-> converting && !sclk && $stable(sw.pos_chan)) else $error("hold bad");
   AST_CONV: assert property ($rose(converting) |-> !sw.track) else $error("conv in track");
   AST_STEPS: assert property ($rose(converting) ##1 ctrl.op_mode == actb_pkg::MODE_INT_CLK
      |-> ##[58:78] conv_done) else $error("conv length");
   AST_RECON: assert property (conv_done |-> ##[0:2] sw.hold_capacitor_to_pos) else $error("no reconnect");
   AST_SGL: assert property ($past(converting) && converting && ctrl.input_config_select
      |-> sw.neg_to_common && sw.neg_chan == 4'h0) else $error("neg not common");
   AST_DIF: assert property ($past(converting) && converting && !ctrl.input_config_select
      && ctrl.chan_select == actb_pkg::SEL_D |-> sw.pos_chan == 4'h8 && sw.neg_chan == 4'h4) else $error("pair");
   AST_POS: assert property ($past(converting) && converting && ctrl.input_config_select
      && ctrl.chan_select == actb_pkg::SEL_A |-> sw.pos_chan == 4'h1) else $error("channel");
   AST_CODE: assert property (conv_done |=> result == {$past(sar_code[9]) ^ !$past(ctrl.polarity_select),
      $past(sar_code[8:0])}) else $error("coding");
   AST_PD: assert property (powered_down |-> !ctrl.op_mode[1]) else $error("power mode");
   cover property (conv_done);
   cover property ($fell(sw.track));
   cover property (powered_down);
   cover property ($rose(converting) ##1 ctrl.op_mode == actb_pkg::MODE_EXT_CLK);
endmodule : actb_chk
bind actb_core actb_chk i_actb_chk (.clk(clk), .rst(rst), .sclk(sclk), .sar_code(sar_code), .ctrl(ctrl),
   .sw(sw), .converting(converting), .conv_done(conv_done), .result(result), .powered_down(powered_down));
`default_nettype wire

// [testbench/adc_control_byte_track_hold_tb.sv]
// self-checking bench for the control-byte decoder and track/hold sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; $display("Error t=%0t %h %h", $time, a, b); end end
module adc_control_byte_track_hold_tb;
   logic clk, rst, dout, dout_oe, converting, conv_done, powered_down, cs_n, sclk, din;
   logic [9:0] sar_code, result;
   logic [7:0] rx1, rx2;
   actb_pkg::actb_ctrl_s ctrl;
   actb_pkg::actb_switch_s sw;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   actb_core i_actb_core (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din), .sar_code(sar_code),
      .dout(dout), .dout_oe(dout_oe), .ctrl(ctrl), .sw(sw), .converting(converting), .conv_done(conv_done),
      .result(result), .powered_down(powered_down));
   actb_host i_actb_host (.clk(clk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic complete_run();
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run
   task automatic start(input logic [7:0] tx, input logic [9:0] sar);
      sar_code <= sar;
      i_actb_host.sel(1'b0);
      i_actb_host.xfer(8'h00, rx1);
      i_actb_host.xfer(tx, rx1);
      repeat (6) @(posedge clk);
      `CHK(ctrl, tx[6:0])
   endtask : start
   task automatic wait_done(input logic [9:0] exp);
      for (int n = 0; n < 300 && conv_done !== 1'b1; n++) @(posedge clk);
      repeat (3) @(posedge clk);
      `CHK(result, exp)
      `CHK(sw.hold_capacitor_to_pos, 1'b1)
   endtask : wait_done
   task automatic read_out(input logic [9:0] exp);
      i_actb_host.xfer(8'h00, rx1);
      i_actb_host.xfer(8'h00, rx2);
      `CHK({rx1[6:0], rx2[7:5]}, exp)
      `CHK(dout_oe, 1'b1)
      i_actb_host.sel(1'b1);
      `CHK(dout_oe, 1'b0)
   endtask : read_out
   task automatic t_single();
      start(8'h9e, 10'h2a5);
      `CHK(sw.track, 1'b0)
      `CHK(converting, 1'b1)
      `CHK(sw.pos_chan, 4'h1)
      `CHK(sw.neg_to_common, 1'b1)
      wait_done(10'h2a5);
      read_out(10'h2a5);
   endtask : t_single
   task automatic t_diff();
      start(8'he2, 10'h155);
      `CHK(sw.pos_chan, 4'h8)
      `CHK(sw.neg_chan, 4'h4)
      wait_done(10'h355);
      read_out(10'h355);
   endtask : t_diff
   task automatic t_codes();
      // remaining table codes: pair in bipolar, then a single channel
      start(8'hd2, 10'h0f0);
      `CHK(sw.pos_chan, 4'h2)
      `CHK(sw.neg_chan, 4'h1)
      wait_done(10'h2f0);
      i_actb_host.sel(1'b1);
      start(8'hae, 10'h0f0);
      `CHK(sw.pos_chan, 4'h4)
      `CHK(sw.neg_to_common, 1'b1)
      wait_done(10'h0f0);
      i_actb_host.sel(1'b1);
   endtask : t_codes
   task automatic t_modes();
      for (int m = 0; m < 3; m++) begin
         start({6'h27, m[1:0]}, 10'h0c3);
         wait_done(10'h0c3);
         i_actb_host.sel(1'b1);
         `CHK(powered_down, logic'(m < 2))
      end
   endtask : t_modes
   task automatic t_ext();
      // conversion paced by the serial clock; decisions leave on the same falls
      start(8'h9f, 10'h3c3);
      read_out(10'h3c3);
      `CHK(result, 10'h3c3)
      `CHK(sw.hold_capacitor_to_pos, 1'b1)
      `CHK(powered_down, 1'b0)
   endtask : t_ext
   initial begin
      rst = 1'b1;
      sar_code = 10'h000;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_single();
      t_diff();
      t_codes();
      t_modes();
      t_ext();
      complete_run();
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         errors++;
         complete_run();
      end
   end
endmodule : adc_control_byte_track_hold_tb
`default_nettype wire
